// file: raster_defs.vh
// timing and field constants for the raster timing generator
`ifndef RASTER_DEFS_VH
`define RASTER_DEFS_VH
// ----------------------------------------------------------------
// horizontal timing, in pixel clocks
// ----------------------------------------------------------------
`define H_ACTIVE 10'd640
`define H_FRONT 10'd16
`define H_SYNC 10'd96
`define H_BACK 10'd48
`define H_TOTAL 10'd800
`define H_LAST 10'd799
// ----------------------------------------------------------------
// vertical timing, in lines
// ----------------------------------------------------------------
`define V_ACTIVE 10'd480
`define V_FRONT 10'd10
`define V_SYNC 10'd2
`define V_BACK 10'd29
`define V_TOTAL 10'd521
`define V_LAST 10'd520
// ----------------------------------------------------------------
// widths and levels
// ----------------------------------------------------------------
`define CNT_W 10
`define COLOUR_W 4
`define PIXEL_W 12
`define ADDR_W 19
`define FIFO_DEPTH 4
`define FIFO_AW 2
`define SYNC_ACTIVE 1'b0
`define SYNC_IDLE 1'b1
`define BLANK_COLOUR 4'h0
`define ZERO_CNT 10'h000
// ----------------------------------------------------------------
// address build, colour fields and flag pipeline
// ----------------------------------------------------------------
`define ADDR_PAD 9
`define ROW_SHIFT_HI 9
`define ROW_SHIFT_LO 7
`define RED_HI 11
`define RED_LO 8
`define GREEN_HI 7
`define GREEN_LO 4
`define BLUE_HI 3
`define BLUE_LO 0
`define FLAG_W 3
`define FLAG_STAGES 3
`define FLAG_ACT 2
`define FLAG_HS 1
`define FLAG_VS 0
`endif

// file: pixel_fifo.v
// small first-word-fall-through fifo for pixel words
module pixel_fifo #(
   parameter WIDTH = 12,
   parameter DEPTH = 4,
   parameter AW = 2
) (
   input wire i_sys_clk,
   input wire i_resetn,
   input wire [WIDTH-1:0] i_wr_data,
   input wire i_wr_valid,
   output wire o_wr_ready,
   output wire [WIDTH-1:0] o_rd_data,
   output wire o_rd_valid,
   input wire i_rd_ready
);
   reg [WIDTH-1:0] mem [0:DEPTH-1];
   reg [AW:0] wr_ptr;
   reg [AW:0] rd_ptr;
   wire [AW:0] used;
   wire push;
   wire pop;

   // ----------------------------------------------------------------
   // status
   // ----------------------------------------------------------------
   // extra pointer bit tells full from empty
   assign used = wr_ptr - rd_ptr;
   assign o_wr_ready = (used != DEPTH[AW:0]);
   assign o_rd_valid = (used != {(AW+1){1'b0}});
   assign push = i_wr_valid & o_wr_ready;
   assign pop = o_rd_valid & i_rd_ready;
   assign o_rd_data = mem[rd_ptr[AW-1:0]];

   // storage, no reset needed on data
   always @(posedge i_sys_clk) begin
      if (push) begin
         mem[wr_ptr[AW-1:0]] <= i_wr_data;
      end
   end

   // pointers
   always @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         wr_ptr <= {(AW+1){1'b0}};
         rd_ptr <= {(AW+1){1'b0}};
      end else begin
         if (push) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (pop) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
      end
   end
endmodule // pixel_fifo

// file: vga_raster_timing_generator.v
// raster timing generator: 640x480 sync, blanking and pixel fetch
//
// How it works
// - four bits per primary, twelve total
// - five outputs: red, green, blue, two syncs
// - all timing from the pixel clock
// - line is 640+16+96+48 = 800 clocks
// - frame is 480+10+2+29 = 521 lines
// - colour blank outside active area
// - column counter advances every pixel clock
// - line counter advances once per line
// - counters free-run and form memory address
// - vertical sync aligned to line wrap
// - pixel colour lands in its own clock
//
// The clock input is the pixel clock. The fetch address leaves the
// counters one clock after they reach a pixel, memory answers one clock
// later, the word is pushed into the fifo and leaves it in the same
// clock as the three-stage delayed blank and sync flags, so colour and
// sync meet at the pins four clocks after the counters.
`include "raster_defs.vh"
module vga_raster_timing_generator (
   input wire i_sys_clk,
   input wire i_resetn,
   input wire i_sync_reset,
   output reg [`ADDR_W-1:0] o_mem_addr,
   output reg o_mem_read,
   input wire [`PIXEL_W-1:0] i_mem_data,
   output reg [`COLOUR_W-1:0] o_red,
   output reg [`COLOUR_W-1:0] o_green,
   output reg [`COLOUR_W-1:0] o_blue,
   output reg o_horizontal_sync_out,
   output reg o_vertical_sync_out,
   output wire o_fifo_overflow
);
   // ----------------------------------------------------------------
   // counters
   // ----------------------------------------------------------------
   reg [`CNT_W-1:0] column;
   reg [`CNT_W-1:0] line;
   wire line_end;
   wire active;
   wire hsync_on;
   wire vsync_on;

   assign line_end = (column == `H_LAST);
   assign active = (column < `H_ACTIVE) && (line < `V_ACTIVE);

   // sync windows sit after the front porch
   assign hsync_on = (column >= (`H_ACTIVE + `H_FRONT)) &&
                     (column < (`H_ACTIVE + `H_FRONT + `H_SYNC));
   assign vsync_on = (line >= (`V_ACTIVE + `V_FRONT)) &&
                     (line < (`V_ACTIVE + `V_FRONT + `V_SYNC));

   // column counter, one step per pixel clock
   always @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         column <= `ZERO_CNT;
      end else if (i_sync_reset) begin
         column <= `ZERO_CNT;
      end else if (line_end) begin
         column <= `ZERO_CNT;
      end else begin
         column <= column + 1'b1;
      end
   end

   // line counter steps at the line wrap; vsync edges share that wrap
   always @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         line <= `ZERO_CNT;
      end else if (i_sync_reset) begin
         line <= `ZERO_CNT;
      end else if (line_end) begin
         if (line == `V_LAST) begin
            line <= `ZERO_CNT;
         end else begin
            line <= line + 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // memory fetch
   // ----------------------------------------------------------------
   // address is row*640 + column, built from two shifts so that no
   // multiplier is needed; the largest sum still fits the address width
   wire [`ADDR_W-1:0] line_wide;
   wire [`ADDR_W-1:0] column_wide;
   wire [`ADDR_W-1:0] row_base;
   assign line_wide = {{`ADDR_PAD{1'b0}}, line};
   assign column_wide = {{`ADDR_PAD{1'b0}}, column};
   assign row_base = (line_wide << `ROW_SHIFT_HI) + (line_wide << `ROW_SHIFT_LO);

   // fetch issued from the counters, never stalled: the counters
   // free-run and the fifo holds at most one word at a time
   always @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_mem_addr <= {`ADDR_W{1'b0}};
         o_mem_read <= 1'b0;
      end else if (i_sync_reset) begin
         o_mem_addr <= {`ADDR_W{1'b0}};
         o_mem_read <= 1'b0;
      end else begin
         o_mem_addr <= row_base + column_wide;
         o_mem_read <= active;
      end
   end

   // ----------------------------------------------------------------
   // flag pipeline
   // ----------------------------------------------------------------
   // blank and sync flags travel with their pixel: one stage for the
   // address register, one for the memory, one for the fifo push
   wire [`FLAG_W-1:0] flags_now;
   wire [`FLAG_W*(`FLAG_STAGES+1)-1:0] flag_chain;
   wire [`FLAG_W-1:0] flags_late;
   wire active_late;
   wire hsync_late;
   wire vsync_late;

   assign flags_now = {active, hsync_on, vsync_on};
   assign flag_chain[`FLAG_W-1:0] = flags_now;

   genvar stage;
   generate
      for (stage = 0; stage < `FLAG_STAGES; stage = stage + 1) begin : g_flag
         reg [`FLAG_W-1:0] held;
         // a restart clears every stage so no old flag outlives it
         always @(posedge i_sys_clk or negedge i_resetn) begin
            if (!i_resetn) begin
               held <= {`FLAG_W{1'b0}};
            end else if (i_sync_reset) begin
               held <= {`FLAG_W{1'b0}};
            end else begin
               held <= flag_chain[stage*`FLAG_W +: `FLAG_W];
            end
         end
         assign flag_chain[(stage+1)*`FLAG_W +: `FLAG_W] = held;
      end
   endgenerate

   // flags of the pixel whose word sits at the fifo head
   assign flags_late = flag_chain[`FLAG_STAGES*`FLAG_W +: `FLAG_W];
   assign active_late = flags_late[`FLAG_ACT];
   assign hsync_late = flags_late[`FLAG_HS];
   assign vsync_late = flags_late[`FLAG_VS];

   // ----------------------------------------------------------------
   // pixel buffer
   // ----------------------------------------------------------------
   // memory answers one clock after the read; every read is pushed,
   // except one that a restart has already cancelled
   reg push_valid;
   always @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         push_valid <= 1'b0;
      end else begin
         push_valid <= o_mem_read & ~i_sync_reset;
      end
   end

   // a word pushed on the restart edge has lost its flags; pop it on
   // the next clock, else every later pixel would land one clock late
   reg fifo_drain;
   always @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         fifo_drain <= 1'b0;
      end else begin
         fifo_drain <= i_sync_reset;
      end
   end

   wire fifo_wr_ready;
   wire fifo_rd_valid;
   wire fifo_rd_ready;
   wire [`PIXEL_W-1:0] fifo_rd_data;

   // the head word is taken in the same clock as its late flags
   assign fifo_rd_ready = active_late | fifo_drain;

   pixel_fifo #(
      .WIDTH(`PIXEL_W),
      .DEPTH(`FIFO_DEPTH),
      .AW(`FIFO_AW)
   ) u_fifo (
      .i_sys_clk(i_sys_clk),
      .i_resetn(i_resetn),
      .i_wr_data(i_mem_data),
      .i_wr_valid(push_valid),
      .o_wr_ready(fifo_wr_ready),
      .o_rd_data(fifo_rd_data),
      .o_rd_valid(fifo_rd_valid),
      .i_rd_ready(fifo_rd_ready)
   );

   // a refused push would mean a lost pixel; flag it for the user
   assign o_fifo_overflow = push_valid & ~fifo_wr_ready;

   // ----------------------------------------------------------------
   // output stage
   // ----------------------------------------------------------------
   // colour only when the late active flag and a word meet, else black;
   // a restart blanks and idles the pins on the very edge it is seen
   always @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_red <= `BLANK_COLOUR;
         o_green <= `BLANK_COLOUR;
         o_blue <= `BLANK_COLOUR;
         o_horizontal_sync_out <= `SYNC_IDLE;
         o_vertical_sync_out <= `SYNC_IDLE;
      end else if (i_sync_reset) begin
         o_red <= `BLANK_COLOUR;
         o_green <= `BLANK_COLOUR;
         o_blue <= `BLANK_COLOUR;
         o_horizontal_sync_out <= `SYNC_IDLE;
         o_vertical_sync_out <= `SYNC_IDLE;
      end else begin
         if (active_late && fifo_rd_valid) begin
            o_red <= fifo_rd_data[`RED_HI:`RED_LO];
            o_green <= fifo_rd_data[`GREEN_HI:`GREEN_LO];
            o_blue <= fifo_rd_data[`BLUE_HI:`BLUE_LO];
         end else begin
            o_red <= `BLANK_COLOUR;
            o_green <= `BLANK_COLOUR;
            o_blue <= `BLANK_COLOUR;
         end
         // active-low sync pulses, aligned with the colour they frame
         o_horizontal_sync_out <= hsync_late ? `SYNC_ACTIVE : `SYNC_IDLE;
         o_vertical_sync_out <= vsync_late ? `SYNC_ACTIVE : `SYNC_IDLE;
      end
   end
   // no divider; i_sys_clk is used directly as the pixel clock
endmodule // vga_raster_timing_generator

// file: raster_chk.sv
// port checker for the raster timing generator
module raster_chk (
   input wire i_sys_clk,
   input wire i_resetn,
   input wire i_sync_reset,
   input wire [18:0] o_mem_addr,
   input wire o_mem_read,
   input wire [11:0] i_mem_data,
   input wire [3:0] o_red,
   input wire [3:0] o_green,
   input wire [3:0] o_blue,
   input wire o_horizontal_sync_out,
   input wire o_vertical_sync_out,
   input wire o_fifo_overflow
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [15:0] hlow, vlow, rrun;
   wire hs = o_horizontal_sync_out;
   wire vs = o_vertical_sync_out;
   wire [11:0] rgb = {o_red, o_green, o_blue};
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_resetn);
   // run lengths, judged only where a run ends
   always @(posedge i_sys_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         hlow <= 16'h0000;
         vlow <= 16'h0000;
         rrun <= 16'h0000;
      end else begin
         hlow <= hs ? 16'h0000 : hlow + 16'h0001;
         vlow <= vs ? 16'h0000 : vlow + 16'h0001;
         rrun <= o_mem_read ? rrun + 16'h0001 : 16'h0000;
      end
   end
   sequence s_hs_fall;
      hs ##1 !hs;
   endsequence
   // colour leaves three clocks after its fetch, data two after it returns
   a_blank_out: assert property (!$past(o_mem_read, 3) |-> rgb == 12'h000)
      else $error("colour not blank");
   a_pixel_path: assert property ($past(o_mem_read, 3) && !$past(i_sync_reset) &&
      !$past(i_sync_reset, 2) && !$past(i_sync_reset, 3) |-> rgb == $past(i_mem_data, 2))
      else $error("colour not fetched word");
   a_addr_step: assert property (o_mem_read && $past(o_mem_read) |->
      o_mem_addr == $past(o_mem_addr) + 19'h00001)
      else $error("address step");
   a_read_run: assert property ($fell(o_mem_read) && !$past(i_sync_reset) |-> rrun == 16'd640)
      else $error("active run length");
   a_hs_width: assert property ($rose(hs) && !$past(i_sync_reset) |-> hlow == 16'd96)
      else $error("hsync width");
   a_hs_porch: assert property (disable iff (!i_resetn || i_sync_reset)
      $fell(o_mem_read) && !$past(i_sync_reset) |-> ##18 s_hs_fall)
      else $error("hsync front porch");
   a_vs_width: assert property ($rose(vs) && !$past(i_sync_reset) |-> vlow == 16'd1600)
      else $error("vsync width");
   a_sync_reset: assert property (i_sync_reset |=> o_mem_addr == 19'h00000 && !o_mem_read &&
      hs && vs && rgb == 12'h000)
      else $error("sync reset state");
   a_no_overflow: assert property (!o_fifo_overflow)
      else $error("pixel fifo overflow");
endmodule // raster_chk

bind vga_raster_timing_generator raster_chk i_chk (.i_sys_clk, .i_resetn, .i_sync_reset,
   .o_mem_addr, .o_mem_read, .i_mem_data, .o_red, .o_green, .o_blue, .o_horizontal_sync_out,
   .o_vertical_sync_out, .o_fifo_overflow);

// file: video_mem_model.sv
// video memory model answering each fetch one clock later
module video_mem_model (
   input wire i_sys_clk,
   input wire [18:0] i_addr,
   input wire i_read,
   output logic [11:0] o_data
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [11:0] word = 12'h000;
   // one clock of read latency; outside fetches the word inverts
   // every clock, so a sample taken at the wrong edge cannot pass
   always @(posedge i_sys_clk) begin
      word <= i_read ? (i_addr[11:0] ^ 12'h5A3) : ~word;
   end
   assign o_data = word;
endmodule // video_mem_model

// file: vga_raster_timing_generator_tb_top.sv
// self-checking bench for the raster timing generator
module vga_raster_timing_generator_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic i_sys_clk = 1'b0;
   logic i_resetn = 1'b0;
   logic i_sync_reset = 1'b0;
   wire [18:0] o_mem_addr;
   wire [11:0] i_mem_data;
   wire [3:0] o_red, o_green, o_blue;
   wire o_mem_read, o_horizontal_sync_out, o_vertical_sync_out, o_fifo_overflow;
   int err_total = 0;
   int checks = 0;
   // 100 ns clock
   initial forever #50 i_sys_clk = ~i_sys_clk;
   vga_raster_timing_generator i_dut (.i_sys_clk, .i_resetn, .i_sync_reset, .o_mem_addr,
      .o_mem_read, .i_mem_data, .o_red, .o_green, .o_blue, .o_horizontal_sync_out,
      .o_vertical_sync_out, .o_fifo_overflow);
   video_mem_model i_mem (.i_sys_clk, .i_addr(o_mem_addr), .i_read(o_mem_read),
      .o_data(i_mem_data));
   task check(input string what, input logic [18:0] exp, input logic [18:0] got);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task test_done;
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // parked outputs: no fetch, syncs high, colour blank
   task idle_chk(input string what);
      check(what, 19'h00000, o_mem_addr);
      check(what, 19'h03000, {4'h0, o_mem_read, o_horizontal_sync_out, o_vertical_sync_out,
         o_red, o_green, o_blue});
   endtask
   task t_reset;
      repeat (9) @(posedge i_sys_clk);
      @(negedge i_sys_clk);
      idle_chk("async reset");
      @(posedge i_sys_clk);
      i_resetn <= 1'b1;
      @(negedge i_sys_clk);
      $display("reset test done");
   endtask
   // two whole lines from the first fetch; phase-free totals
   task t_scan;
      logic [18:0] idx, pa0, pa1, pa2, exp_col;
      logic [2:0] pr;
      int nrd, nhs, n;
      idx = 19'h0;
      pa0 = 19'h0;
      pa1 = 19'h0;
      pa2 = 19'h0;
      exp_col = 19'h0;
      pr = 3'b000;
      nrd = 0;
      nhs = 0;
      n = 0;
      while (o_mem_read !== 1'b1 && n < 20) begin
         @(negedge i_sys_clk);
         n++;
      end
      if (n == 20) begin
         err_total++;
         test_done;
      end
      repeat (1600) begin
         if (o_mem_read === 1'b1) begin
            check("address", idx, o_mem_addr);
            idx++;
            nrd++;
         end
         // colour leaves three clocks after its fetch is seen
         exp_col = pr[2] ? {7'h00, pa2[11:0] ^ 12'h5A3} : 19'h0;
         check("colour", exp_col, {7'h00, o_red, o_green, o_blue});
         check("vsync", 19'h1, {18'h0, o_vertical_sync_out});
         check("overflow", 19'h0, {18'h0, o_fifo_overflow});
         nhs += (o_horizontal_sync_out === 1'b0);
         pr = {pr[1:0], o_mem_read === 1'b1};
         pa2 = pa1;
         pa1 = pa0;
         pa0 = o_mem_addr;
         @(negedge i_sys_clk);
      end
      check("fetches", 19'd1280, 19'(nrd));
      check("hsync low", 19'd192, 19'(nhs));
      $display("scan test done");
   endtask
   // restart two pixels into the third line; fetches must begin again at address zero
   task t_sreset;
      @(posedge i_sys_clk);
      i_sync_reset <= 1'b1;
      @(posedge i_sys_clk);
      i_sync_reset <= 1'b0;
      @(negedge i_sys_clk);
      idle_chk("sync reset");
      t_scan;
   endtask
   initial begin
      t_reset;
      t_scan;
      t_sreset;
      test_done;
   end
endmodule // vga_raster_timing_generator_tb_top
